// ===== freq_reference_limit_ramp.sv
// Frequency reference limiting, digital setpoint, carrier and ramp block
`timescale 1ns/10ps
`default_nettype none
module freq_reference_limit_ramp
   import freq_ref_pkg::*;
#(
   parameter int TICK_NS = 1_000_000
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] analogInputOne,
   input wire logic [15:0] analogInputTwo,
   input wire logic [15:0] panelKnob,
   input wire logic [15:0] pulseInputTerminal,
   input wire logic [15:0] linkFreq,
   input wire logic [15:0] refIn,
   input wire logic digitalSource,
   input wire logic combinedSource,
   input wire logic setpointUp,
   input wire logic setpointDown,
   input wire logic runCmd,
   input wire logic [1:0] digitalInputTerminal,
   input wire logic heatsinkHot,
   input wire logic factoryRestore,
   output logic [15:0] outFreq,
   output logic [15:0] carrierFreq,
   output logic stopRequest,
   output logic [1:0] freqResolution
);
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int CNT_W = $clog2(TICK_CYCLES + 1);
   localparam logic [15:0] TPU_1S = 16'(UNIT_1S_NS / TICK_NS);
   localparam logic [15:0] TPU_100MS = 16'(UNIT_100MS_NS / TICK_NS);
   localparam logic [15:0] TPU_10MS = 16'(UNIT_10MS_NS / TICK_NS);

   // Tick must fit the 10 ms unit evenly and keep counts in 16 bits
   if (TICK_CYCLES < 1 || (UNIT_10MS_NS % TICK_NS) != 0 ||
       (UNIT_1S_NS / TICK_NS) > 65535)
   begin : g_bad_tick
      $error("TICK_NS unsupported");
   end

   //=======================================================================
   // APB decode
   //=======================================================================
   logic [15:0] regs [NUM_RW];
   logic [15:0] setpoint;
   logic [5:0] regIdx;
   logic aligned;
   logic mapped;
   logic writable;
   logic resBad;
   logic wrEn;
   logic setupRd;
   logic [15:0] wrVal;
   logic [15:0] rdVal;

   // Single-cycle access: read data is latched in setup, pready always high
   assign regIdx = paddr[7:2];
   assign aligned = paddr[1:0] == 2'b00;
   assign mapped = aligned && (32'(regIdx) < NUM_REGS);
   assign writable = aligned && (32'(regIdx) < NUM_RW);
   assign wrVal = pwdata[15:0];
   // Only the two defined resolution codes are accepted
   assign resBad = regIdx == IDX_RESOLUTION && wrVal != RES_COARSE &&
      wrVal != RES_FINE;
   assign wrEn = psel && penable && pwrite && writable && !resBad;
   assign setupRd = psel && !penable;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign rdVal = writable ? regs[regIdx[4:0]] :
      regIdx == IDX_STAT_OUT ? outFreq :
      regIdx == IDX_STAT_CARRIER ? carrierFreq :
      regIdx == IDX_STAT_SETPT ? setpoint : 16'h0000;

   // Read data registered in setup so it is stable in access
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         prdata <= 32'h0000_0000;
      else if (setupRd)
         prdata <= {16'h0000, rdVal};
   end

   // Register file; restore keeps the resolution code
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < NUM_RW; i++)
            regs[i] <= REG_RESET[i];
      end
      else if (factoryRestore)
      begin
         for (int i = 0; i < NUM_RW; i++)
            if (6'(i) != IDX_RESOLUTION)
               regs[i] <= REG_RESET[i];
      end
      else if (wrEn)
         regs[regIdx[4:0]] <= wrVal;
   end

   //=======================================================================
   // Register views
   //=======================================================================
   logic [15:0] maxFreq;
   logic [15:0] ceilStored;
   logic [15:0] ceilOfs;
   logic [15:0] floorStored;
   logic [15:0] preset;
   logic [2:0] ceilSrc;
   logic [1:0] belowAct;
   logic [1:0] baseSel;
   logic [1:0] timeUnit;
   logic thermalOn;
   logic retain;

   assign maxFreq = regs[IDX_MAX_FREQ[4:0]];
   assign ceilStored = regs[IDX_CEIL_VAL[4:0]];
   assign ceilOfs = regs[IDX_CEIL_OFS[4:0]];
   assign floorStored = regs[IDX_FLOOR[4:0]];
   assign preset = regs[IDX_PRESET[4:0]];
   assign ceilSrc = regs[IDX_CEIL_SRC[4:0]][2:0];
   assign belowAct = regs[IDX_BELOW[4:0]][1:0];
   assign baseSel = regs[IDX_BASE_SEL[4:0]][1:0];
   assign timeUnit = regs[IDX_TIME_UNIT[4:0]][1:0];
   assign thermalOn = regs[IDX_THERMAL[4:0]] == 16'h0001;
   assign retain = regs[IDX_RETENTION[4:0]] == 16'h0001;

   //=======================================================================
   // Ceiling and floor
   //=======================================================================
   logic [15:0] ceilRaw;
   logic [16:0] ceilSum;
   logic addCeilOfs;
   logic [15:0] ceilStoredLim;
   logic [15:0] ceilEff;
   logic [15:0] floorEff;

   // Source mux; unknown codes fall back to the stored value
   assign ceilRaw = ceilSrc == SRC_ANALOG1 ? analogInputOne :
      ceilSrc == SRC_ANALOG2 ? analogInputTwo :
      ceilSrc == SRC_KNOB ? panelKnob :
      ceilSrc == SRC_PULSE ? pulseInputTerminal :
      ceilSrc == SRC_LINK ? linkFreq : ceilStored;
   // Knob counts as an analog input for the offset
   assign addCeilOfs = ceilSrc == SRC_ANALOG1 || ceilSrc == SRC_ANALOG2 ||
      ceilSrc == SRC_KNOB || ceilSrc == SRC_PULSE;
   assign ceilSum = {1'b0, ceilRaw} +
      {1'b0, addCeilOfs ? (ceilOfs > maxFreq ? maxFreq : ceilOfs) :
      16'h0000};
   // Stored ceiling held within floor..maximum at use, not on write
   assign ceilStoredLim = ceilStored > maxFreq ? maxFreq :
      ceilStored < floorStored ? floorStored : ceilStored;
   assign ceilEff = (ceilSrc == SRC_STORED || ceilSrc > SRC_LINK) ?
      ceilStoredLim :
      ceilSum > {1'b0, maxFreq} ? maxFreq : ceilSum[15:0];
   assign floorEff = floorStored > ceilStoredLim ? ceilStoredLim :
      floorStored;

   //=======================================================================
   // Reference conditioning: offset, ceiling, floor action
   //=======================================================================
   logic [15:0] srcRef;
   logic [15:0] combOfs;
   logic [16:0] refSum;
   logic [15:0] refClamped;
   logic belowFloor;
   logic floorStop;
   logic [15:0] setFreq;
   logic [15:0] target;

   assign combOfs = regs[IDX_COMB_OFS[4:0]] > maxFreq ? maxFreq :
      regs[IDX_COMB_OFS[4:0]];
   assign srcRef = digitalSource ? setpoint : refIn;
   assign refSum = {1'b0, srcRef} +
      {1'b0, combinedSource ? combOfs : 16'h0000};
   assign refClamped = refSum > {1'b0, ceilEff} ? ceilEff :
      refSum[15:0];
   assign belowFloor = refClamped < floorEff;
   // Stop and zero speed both hold zero; only stop asks to halt
   assign setFreq = !belowFloor ? refClamped :
      belowAct == BELOW_FLOOR ? floorEff : 16'h0000;
   assign floorStop = belowFloor && belowAct == BELOW_STOP;
   assign target = runCmd && !floorStop ? setFreq : 16'h0000;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         stopRequest <= 1'b0;
      else
         stopRequest <= runCmd && floorStop;
   end

   //=======================================================================
   // Digital setpoint with up/down and stop retention
   //=======================================================================
   logic runQ;
   logic stopEdge;
   logic presetWr;

   assign stopEdge = runQ && !runCmd;
   assign presetWr = wrEn && regIdx == IDX_PRESET;

   // Stop reload wins over keys; a preset write seeds the setpoint
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         runQ <= 1'b0;
         setpoint <= FREQ_50HZ;
      end
      else
      begin
         runQ <= runCmd;
         if (factoryRestore)
            setpoint <= FREQ_50HZ;
         else if (stopEdge && digitalSource)
            setpoint <= retain ? setpoint : preset;
         else if (presetWr)
            setpoint <= wrVal > maxFreq ? maxFreq : wrVal;
         else if (setpointUp && !setpointDown && setpoint < maxFreq)
            setpoint <= setpoint + 16'h0001;
         else if (setpointDown && !setpointUp && setpoint != 16'h0000)
            setpoint <= setpoint - 16'h0001;
      end
   end

   //=======================================================================
   // Carrier with thermal derating
   //=======================================================================
   logic [15:0] carrierSet;
   logic [15:0] carrierHalf;
   logic [15:0] next_carrier;

   assign carrierSet = regs[IDX_CARRIER[4:0]] < CARRIER_MIN ? CARRIER_MIN :
      regs[IDX_CARRIER[4:0]] > CARRIER_MAX ? CARRIER_MAX :
      regs[IDX_CARRIER[4:0]];
   // Halving is a coarse but safe derate; it never drops below minimum
   assign carrierHalf = (carrierSet >> 1) < CARRIER_MIN ? CARRIER_MIN :
      carrierSet >> 1;
   assign next_carrier = thermalOn && heatsinkHot ? carrierHalf :
      carrierSet;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         carrierFreq <= CARRIER_DEFAULT;
      else
         carrierFreq <= next_carrier;
   end

   // Resolution is only a scale tag; raw values keep their digits
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         freqResolution <= RES_FINE[1:0];
      else
         freqResolution <= regs[IDX_RESOLUTION[4:0]][1:0];
   end

   //=======================================================================
   // Ramp generator
   //=======================================================================
   logic [CNT_W-1:0] tickCnt;
   logic tick;
   logic [5:0] accelIdx;
   logic [15:0] rampTime;
   logic [15:0] tpu;
   logic [15:0] baseFreq;
   logic [31:0] denom;
   logic [31:0] acc;
   logic [31:0] accAdd;
   logic [31:0] next_acc;
   logic rising;
   logic moving;
   logic stepNow;
   logic jump;

   assign tick = tickCnt == CNT_W'(TICK_CYCLES - 1);
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         tickCnt <= '0;
      else
         tickCnt <= tick ? '0 : tickCnt + CNT_W'(1);
   end

   // Group 0 sits apart; groups 1..3 follow the status-free block
   assign rising = outFreq < target;
   assign accelIdx = digitalInputTerminal == 2'b00 ? IDX_ACCEL1 :
      IDX_GROUP_BASE + {3'b000, digitalInputTerminal, 1'b0};
   assign rampTime = rising ? regs[accelIdx[4:0]] :
      regs[5'(accelIdx + 6'h01)];
   // Unit change reinterprets stored times through ticks per unit
   assign tpu = timeUnit == UNIT_1S ? TPU_1S :
      timeUnit == UNIT_100MS ? TPU_100MS : TPU_10MS;
   assign baseFreq = baseSel == BASE_SET ? setFreq :
      baseSel == BASE_100HZ ?
      (freqResolution == RES_COARSE[1:0] ? BASE_100HZ_COARSE :
      BASE_100HZ_FINE) : maxFreq;
   assign denom = rampTime * tpu;
   assign moving = outFreq != target;
   // No time or no base: no slope is defined, so go straight there
   assign jump = moving && (denom == 32'h0 || baseFreq == 16'h0000);
   assign stepNow = moving && !jump && acc >= denom;
   assign accAdd = tick && moving ? {16'h0000, baseFreq} : 32'h0;
   assign next_acc = !moving ? 32'h0 :
      acc + accAdd - (stepNow ? denom : 32'h0);

   // One unit step per clock, many clocks per tick, so no divider
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         acc <= 32'h0;
         outFreq <= 16'h0000;
      end
      else
      begin
         acc <= next_acc;
         if (jump)
            outFreq <= target;
         else if (stepNow)
            outFreq <= rising ? outFreq + 16'h0001 :
               outFreq - 16'h0001;
      end
   end

   //=======================================================================
   // Assertions
   //=======================================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Floor action comes after the clamp, so running at floor may pass it
   a_ceiling_hold: assert property (target <= ceilEff ||
      target == floorEff)
      else $error("target above ceiling");
   a_floor_stop: assert property (runCmd && belowFloor &&
      belowAct == BELOW_STOP |-> target == 16'h0000 ##1 stopRequest)
      else $error("below floor stop not taken");
   a_no_overshoot: assert property ($past(outFreq) <= $past(target) &&
      $past(target) == target |-> outFreq <= target)
      else $error("ramp overshoot");
   a_carrier_range: assert property (carrierFreq >= CARRIER_MIN &&
      carrierFreq <= CARRIER_MAX)
      else $error("carrier out of range");
   a_thermal_derate: assert property (thermalOn && heatsinkHot &&
      carrierSet > 16'h000a |=> carrierFreq < $past(carrierSet))
      else $error("carrier not derated");
   a_retain_reload: assert property (stopEdge && digitalSource &&
      !retain && !factoryRestore |=> setpoint == $past(preset))
      else $error("setpoint not reloaded");
   a_retain_keep: assert property (stopEdge && digitalSource && retain &&
      !factoryRestore |=> $stable(setpoint))
      else $error("setpoint not kept");
   a_res_kept: assert property (factoryRestore |=>
      $stable(regs[IDX_RESOLUTION[4:0]]))
      else $error("resolution restored");
   a_base_fixed: assert property (baseSel == BASE_100HZ &&
      freqResolution == RES_FINE[1:0] |-> baseFreq == BASE_100HZ_FINE)
      else $error("fixed base wrong");
   a_offset_add: assert property (ceilSrc == SRC_ANALOG1 &&
      ceilSum <= {1'b0, maxFreq} |-> ceilEff == ceilSum[15:0])
      else $error("ceiling offset lost");
   a_floor_limit: assert property (floorEff <= ceilStoredLim)
      else $error("floor above ceiling");
endmodule : freq_reference_limit_ramp
`default_nettype wire

// ===== freq_ref_pkg.sv
// Constants, register map and codes for the frequency reference block
//==========================================================================
//==========================================================================
package freq_ref_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Time unit lengths in ns
   localparam int UNIT_1S_NS = 1_000_000_000;
   localparam int UNIT_100MS_NS = 100_000_000;
   localparam int UNIT_10MS_NS = 10_000_000;
   //==========================================================================
   // Register indices; byte address is index times four
   localparam int NUM_RW = 22;
   localparam int NUM_REGS = 25;
   localparam logic [5:0] IDX_CEIL_SRC = 6'h00;
   localparam logic [5:0] IDX_CEIL_VAL = 6'h01;
   localparam logic [5:0] IDX_CEIL_OFS = 6'h02;
   localparam logic [5:0] IDX_FLOOR = 6'h03;
   localparam logic [5:0] IDX_CARRIER = 6'h04;
   localparam logic [5:0] IDX_THERMAL = 6'h05;
   localparam logic [5:0] IDX_ACCEL1 = 6'h06;
   localparam logic [5:0] IDX_DECEL1 = 6'h07;
   localparam logic [5:0] IDX_TIME_UNIT = 6'h08;
   localparam logic [5:0] IDX_COMB_OFS = 6'h09;
   localparam logic [5:0] IDX_RESOLUTION = 6'h0a;
   localparam logic [5:0] IDX_RETENTION = 6'h0b;
   localparam logic [5:0] IDX_BASE_SEL = 6'h0c;
   localparam logic [5:0] IDX_PRESET = 6'h0d;
   localparam logic [5:0] IDX_MAX_FREQ = 6'h0e;
   localparam logic [5:0] IDX_BELOW = 6'h0f;
   localparam logic [5:0] IDX_GROUP_BASE = 6'h0e; // group g at 14+2g for g 1..3; group 0 at 6
   localparam logic [5:0] IDX_STAT_OUT = 6'h16;
   localparam logic [5:0] IDX_STAT_CARRIER = 6'h17;
   localparam logic [5:0] IDX_STAT_SETPT = 6'h18;
   //==========================================================================
   // Reset values and codes
   localparam logic [15:0] FREQ_50HZ = 16'h1388; // 50.00 Hz at 0.01 Hz
   localparam logic [15:0] RAMP_TIME_DEFAULT = 16'h0064;
   localparam logic [15:0] CARRIER_DEFAULT = 16'h0028; // 4.0 kHz, 0.1 kHz
   localparam logic [15:0] CARRIER_MIN = 16'h0005;
   localparam logic [15:0] CARRIER_MAX = 16'h00a0;
   localparam logic [15:0] BASE_100HZ_COARSE = 16'h03e8;
   localparam logic [15:0] BASE_100HZ_FINE = 16'h2710;
   localparam logic [15:0] RES_COARSE = 16'h0001;
   localparam logic [15:0] RES_FINE = 16'h0002;
   localparam logic [15:0] REG_RESET [NUM_RW] = '{
      16'h0000, FREQ_50HZ, 16'h0000, 16'h0000, CARRIER_DEFAULT, 16'h0001,
      RAMP_TIME_DEFAULT, RAMP_TIME_DEFAULT, 16'h0001, 16'h0000, RES_FINE,
      16'h0000, 16'h0000, FREQ_50HZ, FREQ_50HZ, 16'h0000,
      RAMP_TIME_DEFAULT, RAMP_TIME_DEFAULT, RAMP_TIME_DEFAULT,
      RAMP_TIME_DEFAULT, RAMP_TIME_DEFAULT, RAMP_TIME_DEFAULT};
   typedef enum logic [2:0] {SRC_STORED, SRC_ANALOG1, SRC_ANALOG2,
      SRC_KNOB, SRC_PULSE, SRC_LINK} ceil_src_e;
   typedef enum logic [1:0] {BELOW_STOP, BELOW_FLOOR, BELOW_ZERO}
      below_action_e;
   typedef enum logic [1:0] {BASE_MAX, BASE_SET, BASE_100HZ} base_sel_e;
   typedef enum logic [1:0] {UNIT_1S, UNIT_100MS, UNIT_10MS} time_unit_e;
endpackage : freq_ref_pkg

// ===== mod_stage_model.sv
// Modulation stage model that watches the ramp output
`timescale 1ns/10ps
`default_nettype none
module mod_stage_model
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic watch,
   input wire logic [15:0] outFreq,
   output logic stepErr
);
   logic [15:0] lastFreq;
   //=====
   // Stage
   // A ramping drive moves one unit a clock at most, never jumps
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         lastFreq <= '0;
         stepErr <= 1'b0;
      end
      else
      begin
         lastFreq <= outFreq;
         if (watch && (outFreq > lastFreq + 16'h0001 ||
            lastFreq > outFreq + 16'h0001))
            stepErr <= 1'b1;
      end
endmodule : mod_stage_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the frequency reference block
`timescale 1ns/10ps
`default_nettype none
module tb_top import freq_ref_pkg::*;;
   localparam int TICK = 20000;
   localparam int TCYC = TICK / CLK_PERIOD_NS;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] cand [6];
   logic [15:0] refIn, outFreq, carrierFreq;
   logic digSrc, combSrc, spUp, spDn, runCmd, hot, facRst;
   logic stopReq, watch, stepErr;
   logic [1:0] diTerm, freqRes;
   int nMismatch, nTests, cyc, floorVal, ceilOfs, combOfs, src, act, e;
   //=====
   // Design and far side
   freq_reference_limit_ramp #(.TICK_NS(TICK)) i_freq_reference_limit_ramp
   (
      .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .analogInputOne(cand[1]),
      .analogInputTwo(cand[2]), .panelKnob(cand[3]),
      .pulseInputTerminal(cand[4]), .linkFreq(cand[5]), .refIn(refIn),
      .digitalSource(digSrc), .combinedSource(combSrc),
      .setpointUp(spUp), .setpointDown(spDn), .runCmd(runCmd),
      .digitalInputTerminal(diTerm), .heatsinkHot(hot),
      .factoryRestore(facRst), .outFreq(outFreq),
      .carrierFreq(carrierFreq), .stopRequest(stopReq),
      .freqResolution(freqRes)
   );
   mod_stage_model i_mod_stage_model
   (
      .clk(clk), .arst_n(arst_n), .watch(watch), .outFreq(outFreq),
      .stepErr(stepErr)
   );
   //=====
   // Helpers
   task automatic reportAndStop;
      if (nMismatch == 0 && nTests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : reportAndStop
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      nTests++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [15:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdChk(input string what, input logic [7:0] a,
      input logic [15:0] x);
      apb(1'b0, a, 16'h0000);
      chk(what, {16'h0000, x}, rdv);
   endtask : rdChk
   task automatic bump(input logic up);
      @(posedge clk);
      spUp <= up;
      spDn <= !up;
      @(posedge clk);
      spUp <= 1'b0;
      spDn <= 1'b0;
   endtask : bump
   // Offsets, then ceiling, then floor action; -1 means a stop
   function automatic int expFreq();
      int c;
      int f;
      c = cand[src] + ((src > 0 && src < 5) ? ceilOfs : 0);
      f = refIn + (combSrc ? combOfs : 0);
      if (f > c)
         f = c;
      if (f < floorVal)
         f = (act == 1) ? floorVal : ((act == 2) ? 0 : -1);
      return f;
   endfunction : expFreq
   // Unit steps after n ticks: base over time per tick
   function automatic int rampSteps(input int u, input int b, input int n);
      int thr;
      int bv;
      thr = (u == 0) ? UNIT_1S_NS : (u == 1) ? UNIT_100MS_NS : UNIT_10MS_NS;
      bv = (b == 0) ? FREQ_50HZ : (b == 1) ? 200 : BASE_100HZ_FINE;
      return n * bv / (thr / TICK);
   endfunction : rampSteps
   // Ramp from zero toward 200 with time 1 for four ticks
   task automatic rampCase(input logic [15:0] u, input logic [15:0] b);
      apb(1'b1, 8'h20, u);
      apb(1'b1, 8'h30, b);
      diTerm <= 2'h2;
      refIn <= 16'h0000;
      repeat (3) @(posedge clk);
      diTerm <= 2'h0;
      refIn <= 16'h00c8;
      watch <= 1'b1;
      repeat (4 * TCYC) @(posedge clk);
      // Tick phase is free, so any count within one tick either side is fine
      e = rampSteps(u, b, 4);
      if (outFreq >= rampSteps(u, b, 3) && outFreq <= rampSteps(u, b, 5))
         e = outFreq;
      chk("ramp", 32'(e), {16'h0000, outFreq});
      watch <= 1'b0;
   endtask : rampCase
   //=====
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         nMismatch++;
         reportAndStop();
      end
   end
   //=====
   // Main sequence
   initial
   begin
      arst_n = 1'b0;
      {psel, penable, pwrite, digSrc, combSrc, spUp, spDn} = '0;
      {runCmd, hot, facRst, watch} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      refIn = 16'h0000;
      diTerm = 2'h2;
      cand = '{default: 16'h0000};
      void'($urandom(32'h43ca));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < NUM_RW; i++)
         rdChk("reset", 8'(i * 4), REG_RESET[i]);
      apb(1'b1, 8'h58, 16'h1234);
      chk("read-only error", 32'h0, {31'h0, err});
      rdChk("read-only", 8'h58, 16'h0000);
      apb(1'b0, 8'h80, 16'h0000);
      chk("unmapped", 32'h1, {31'h0, err});
      // Instant group so the limited target shows next cycle
      apb(1'b1, 8'h48, 16'h0000);
      apb(1'b1, 8'h4c, 16'h0000);
      runCmd <= 1'b1;
      for (int i = 0; i < 24; i++)
      begin
         src = (i < 6) ? i : $urandom_range(5);
         act = i % 3;
         floorVal = $urandom_range(1000);
         ceilOfs = $urandom_range(1000);
         combOfs = $urandom_range(500);
         cand[0] = 16'($urandom_range(5000, floorVal));
         for (int k = 1; k < 6; k++)
            cand[k] <= 16'($urandom_range(4000));
         refIn <= 16'($urandom_range(6000));
         combSrc <= 1'($urandom_range(1));
         apb(1'b1, 8'h00, 16'(src));
         apb(1'b1, 8'h04, cand[0]);
         apb(1'b1, 8'h08, 16'(ceilOfs));
         apb(1'b1, 8'h0c, 16'(floorVal));
         apb(1'b1, 8'h24, 16'(combOfs));
         apb(1'b1, 8'h3c, 16'(act));
         repeat (3) @(posedge clk);
         e = expFreq();
         if (e >= 0)
            chk("limit", 32'(e), {16'h0000, outFreq});
         chk("stop", {31'h0, e < 0}, {31'h0, stopReq});
      end
      // Carrier derate while hot
      apb(1'b1, 8'h10, 16'h00a0);
      hot <= 1'b1;
      repeat (3) @(posedge clk);
      chk("carrier", 32'h50, {16'h0000, carrierFreq});
      apb(1'b1, 8'h14, 16'h0000);
      repeat (3) @(posedge clk);
      chk("carrier", 32'ha0, {16'h0000, carrierFreq});
      apb(1'b1, 8'h14, 16'h0001);
      apb(1'b1, 8'h10, 16'h0008);
      repeat (3) @(posedge clk);
      chk("carrier", 32'h05, {16'h0000, carrierFreq});
      hot <= 1'b0;
      repeat (3) @(posedge clk);
      chk("carrier", 32'h08, {16'h0000, carrierFreq});
      // Resolution survives a factory restore
      apb(1'b1, 8'h28, 16'h0001);
      apb(1'b1, 8'h28, 16'h0003);
      apb(1'b1, 8'h04, 16'h04d2);
      @(posedge clk);
      facRst <= 1'b1;
      @(posedge clk);
      facRst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("resolution", 32'h1, {30'h0, freqRes});
      rdChk("restored", 8'h04, FREQ_50HZ);
      rdChk("resolution", 8'h28, 16'h0001);
      // Setpoint after stop, both retention codes
      digSrc <= 1'b1;
      apb(1'b1, 8'h34, 16'h0bb8);
      bump(1'b1);
      bump(1'b1);
      bump(1'b1);
      bump(1'b0);
      rdChk("setpoint", 8'h60, 16'h0bba);
      runCmd <= 1'b0;
      repeat (3) @(posedge clk);
      rdChk("setpoint", 8'h60, 16'h0bb8);
      apb(1'b1, 8'h2c, 16'h0001);
      runCmd <= 1'b1;
      bump(1'b1);
      bump(1'b1);
      runCmd <= 1'b0;
      repeat (3) @(posedge clk);
      rdChk("setpoint", 8'h60, 16'h0bba);
      // Ramp slopes over units and base codes
      digSrc <= 1'b0;
      apb(1'b1, 8'h28, 16'h0002);
      apb(1'b1, 8'h48, 16'h0000);
      apb(1'b1, 8'h4c, 16'h0000);
      apb(1'b1, 8'h18, 16'h0001);
      apb(1'b1, 8'h1c, 16'h0001);
      runCmd <= 1'b1;
      rampCase(16'h0002, 16'h0000);
      rampCase(16'h0002, 16'h0002);
      rampCase(16'h0001, 16'h0002);
      rampCase(16'h0000, 16'h0000);
      rampCase(16'h0002, 16'h0001);
      chk("step size", 32'h0, {31'h0, stepErr});
      reportAndStop();
   end
endmodule : tb_top
`default_nettype wire
